// ### design/prs_sequencer.sv
// protection and restart sequencer with auto recovery timer
//
// Contract
// - separate interval timers make all protection intervals and restart delays
// - overcurrent trip turns the switch off immediately
// - after overcurrent, hold stop for the hold interval, then resume
// - surge over limit stops switching at once
// - surge clearing before its interval resumes at once, no start-up
// - long surge: low power until safe, then start-up sequence
// - long low input: low power, wait recovery interval, restart via reload
// - low input detection only in active, masked in soft-start
// - long feedback loss stops switching and enters low power
// - feedback loss masked in soft-start; recover after recovery interval
// - feedback pin low suppresses switching until it rises again
// - control pin low forces low power; release begins soft-start
// - control pin long high enters low power, recovered after interval
// - every low power entry discharges soft-start and clears its timing
// - start-up source on in low power, off in stop and active
`include "prs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer
  import prs_pkg::*;
(
  input  wire logic clk_i,                       // 10 MHz clock
  input  wire logic rst_b_i,                     // sync reset, active low
  input  wire logic switch_overcurrent_trip_i,   // fast overcurrent flag
  input  wire logic input_surge_trip_i,          // input above surge limit
  input  wire logic low_input_trip_i,            // clamp current below limit
  input  wire logic feedback_loss_trip_i,        // no pull-down or overload
  input  wire logic feedback_pull_low_disable_i, // feedback pin held low
  input  wire logic control_pull_low_disable_i,  // control pin held low
  input  wire logic control_pull_high_disable_i, // control pin above high thr
  input  wire logic supply_ready_i,              // supply reached turn-on level
  output logic      switch_enable_o,             // gate switching allowed
  output logic      startup_supply_source_o,     // high voltage source on
  output logic      soft_start_reset_o,          // discharge soft-start cap
  output logic      soft_start_active_o,         // soft-start phase running
  output logic      low_power_o,                 // low consumption mode
  output logic      stop_o                       // stop mode
);
  localparam int W = `PRS_CNT_W;
  localparam logic [W-1:0] OCP_CYC   = W'(`PRS_US2CYC(`PRS_OCP_HOLD_US));
  localparam logic [W-1:0] SURGE_CYC = W'(`PRS_US2CYC(`PRS_SURGE_US));
  localparam logic [W-1:0] LOWIN_CYC = W'(`PRS_US2CYC(`PRS_LOWIN_US));
  localparam logic [W-1:0] FBL_CYC   = W'(`PRS_US2CYC(`PRS_FBLOSS_US));
  localparam logic [W-1:0] DIS_CYC   = W'(`PRS_US2CYC(`PRS_DIS_US));
  localparam logic [W-1:0] REC_CYC   = W'(`PRS_US2CYC(`PRS_REC_US));
  localparam logic [W-1:0] SOFT_CYC  = W'(`PRS_US2CYC(`PRS_SOFT_US));

  prs_state_t state_q;
  logic       stop_ocp_q;     // stop caused by overcurrent, else by surge
  logic       rec_reload_q;   // recovery ends in reload, else waits safe input
  logic [3:0] qual;
  logic [3:0] exp_w;
  logic       hold_exp;
  logic       rec_exp;
  logic       soft_exp;
  logic [W-1:0] terms [4];

  // qualifying conditions; feedback loss and low input only in active
  assign qual[0] = input_surge_trip_i && state_q != PRS_ST_LOWPWR
                   && state_q != PRS_ST_RECOVER;
  assign qual[1] = low_input_trip_i && state_q == PRS_ST_ACTIVE;
  assign qual[2] = feedback_loss_trip_i && state_q == PRS_ST_ACTIVE;
  assign qual[3] = control_pull_high_disable_i
                   && (state_q == PRS_ST_ACTIVE || state_q == PRS_ST_SOFT);
  assign terms[0] = SURGE_CYC;
  assign terms[1] = LOWIN_CYC;
  assign terms[2] = FBL_CYC;
  assign terms[3] = DIS_CYC;

  // qualifying intervals come from one timer bank; hold, recovery and soft-start have their own
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_qual
      prs_interval_timer #(.W(W)) u_tmr (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .qual_i    (qual[g]),
        .term_i    (terms[g]),
        .expired_o (exp_w[g])
      );
    end
  endgenerate

  prs_interval_timer #(.W(W)) u_hold (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .qual_i    (state_q == PRS_ST_STOP && stop_ocp_q),
    .term_i    (OCP_CYC),
    .expired_o (hold_exp)
  );

  prs_interval_timer #(.W(W)) u_rec (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .qual_i    (state_q == PRS_ST_RECOVER && rec_reload_q),
    .term_i    (REC_CYC),
    .expired_o (rec_exp)
  );

  // soft-start timing held at zero outside soft-start
  prs_interval_timer #(.W(W)) u_soft (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .qual_i    (state_q == PRS_ST_SOFT),
    .term_i    (SOFT_CYC),
    .expired_o (soft_exp)
  );

  // control pin low overrides everything but reset, it is the user's hard off
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_q      <= PRS_ST_LOWPWR;
      stop_ocp_q   <= 1'b0;
      rec_reload_q <= 1'b0;
    end
    else if (control_pull_low_disable_i)
    begin
      state_q      <= PRS_ST_LOWPWR;
      rec_reload_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        PRS_ST_LOWPWR:
          if (supply_ready_i)
            state_q <= PRS_ST_SOFT;
        PRS_ST_SOFT, PRS_ST_ACTIVE:
          if (switch_overcurrent_trip_i)
          begin
            state_q    <= PRS_ST_STOP;
            stop_ocp_q <= 1'b1;
          end
          else if (input_surge_trip_i)
          begin
            state_q    <= PRS_ST_STOP;
            stop_ocp_q <= 1'b0;
          end
          else if (exp_w[1] || exp_w[2] || exp_w[3])
          begin
            state_q      <= PRS_ST_RECOVER;
            rec_reload_q <= 1'b1;
          end
          else if (state_q == PRS_ST_SOFT && soft_exp)
            state_q <= PRS_ST_ACTIVE;
        PRS_ST_STOP:
          if (stop_ocp_q)
          begin
            if (hold_exp)
              state_q <= PRS_ST_ACTIVE;
          end
          else if (!input_surge_trip_i)
            state_q <= PRS_ST_ACTIVE;
          else if (exp_w[0])
          begin
            state_q      <= PRS_ST_RECOVER;
            rec_reload_q <= 1'b0;
          end
        PRS_ST_RECOVER:
          if (rec_reload_q ? rec_exp : !input_surge_trip_i)
            state_q <= PRS_ST_SOFT;
        default:
          state_q <= PRS_ST_LOWPWR;
      endcase
    end
  end

  // outputs registered; switching gated combinationally-free by next cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      switch_enable_o         <= 1'b0;
      startup_supply_source_o <= 1'b1;
      soft_start_reset_o      <= 1'b1;
      soft_start_active_o     <= 1'b0;
      low_power_o             <= 1'b1;
      stop_o                  <= 1'b0;
    end
    else
    begin
      // overcurrent and surge trips drop the enable on their first sampled edge
      switch_enable_o <= (state_q == PRS_ST_SOFT || state_q == PRS_ST_ACTIVE)
                         && !switch_overcurrent_trip_i
                         && !input_surge_trip_i
                         && !feedback_pull_low_disable_i
                         && !control_pull_low_disable_i;
      startup_supply_source_o <= state_q == PRS_ST_LOWPWR
                                 || state_q == PRS_ST_RECOVER;
      soft_start_reset_o <= state_q == PRS_ST_LOWPWR
                            || state_q == PRS_ST_RECOVER;
      soft_start_active_o <= state_q == PRS_ST_SOFT;
      low_power_o <= state_q == PRS_ST_LOWPWR || state_q == PRS_ST_RECOVER;
      stop_o      <= state_q == PRS_ST_STOP;
    end
  end
endmodule // prs_sequencer
`default_nettype wire

// ### common/prs_regs.svh
// timing constants for the protection and restart sequencer
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
`define PRS_CLK_HZ          10000000
`define PRS_CNT_W           24
// interval figures in microseconds; plain defaults, kept short so that
// every protection and recovery path can be exercised in a short run
`define PRS_OCP_HOLD_US     100
`define PRS_SURGE_US        1000
`define PRS_LOWIN_US        300
`define PRS_FBLOSS_US       400
`define PRS_DIS_US          250
`define PRS_REC_US          300
`define PRS_SOFT_US         1000
`define PRS_US2CYC(us)      ((us) * (`PRS_CLK_HZ / 1000000))
`endif

// ### common/prs_pkg.sv
// types for the protection and restart sequencer
package prs_pkg;
  typedef enum logic [2:0] {
    PRS_ST_LOWPWR,
    PRS_ST_SOFT,
    PRS_ST_ACTIVE,
    PRS_ST_STOP,
    PRS_ST_RECOVER
  } prs_state_t;
endpackage

// ### design/prs_interval_timer.sv
// qualifying interval counter with configurable terminal count
`timescale 1ns/1ps
`default_nettype none
module prs_interval_timer
  import prs_pkg::*;
#(
  parameter int W = 24
)(
  input  wire logic         clk_i,     // system clock
  input  wire logic         rst_b_i,   // sync reset, active low
  input  wire logic         qual_i,    // qualifying condition present
  input  wire logic [W-1:0] term_i,    // terminal count in cycles
  output logic              expired_o  // high once count reaches term
);
  logic [W-1:0] cnt_q;

  // restarts from zero whenever the condition drops out
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || !qual_i)
    begin
      cnt_q     <= '0;
      expired_o <= 1'b0;
    end
    else if (cnt_q >= term_i)
      expired_o <= 1'b1;
    else
      cnt_q <= cnt_q + 1'b1;
  end
endmodule // prs_interval_timer
`default_nettype wire

// ### bench/prs_flag_model.sv
// comparator flag model feeding the sequencer's flag inputs
`timescale 1ns/1ps
`default_nettype none
module prs_flag_model (
  input  wire logic [7:0] req_i,  // requested flag levels
  input  wire logic       clk_i,  // system clock
  output logic      [7:0] flag_o  // flags as seen by the block
);
  // comparators settle one clock after the analog event, never sooner
  initial flag_o = 8'h00;
  always @(posedge clk_i)
  begin
    flag_o <= req_i;
  end
endmodule // prs_flag_model
`default_nettype wire

// ### bench/prs_sequencer_sva.sv
// port-level checks for the protection and restart sequencer
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer_sva (
  input wire logic clk_i, rst_b_i, switch_overcurrent_trip_i,
  input wire logic input_surge_trip_i, low_input_trip_i,
  input wire logic feedback_loss_trip_i, feedback_pull_low_disable_i,
  input wire logic control_pull_low_disable_i, supply_ready_i,
  input wire logic control_pull_high_disable_i, switch_enable_o,
  input wire logic startup_supply_source_o, soft_start_reset_o,
  input wire logic soft_start_active_o, low_power_o, stop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_oc_off; switch_overcurrent_trip_i |=> !switch_enable_o; endproperty
  a_oc_off: assert property (p_oc_off) else $error("gate on after trip");
  property p_surge_off; input_surge_trip_i |=> !switch_enable_o; endproperty
  a_surge_off: assert property (p_surge_off) else $error("gate on in surge");
  property p_fb_off; feedback_pull_low_disable_i |=> !switch_enable_o; endproperty
  a_fb_off: assert property (p_fb_off) else $error("gate on, fb low");
  property p_ctl_low; control_pull_low_disable_i [*2] |=> low_power_o; endproperty
  a_ctl_low: assert property (p_ctl_low) else $error("no low power");
  property p_ss_clr;
    $rose(low_power_o) |-> soft_start_reset_o && !soft_start_active_o;
  endproperty
  a_ss_clr: assert property (p_ss_clr) else $error("soft-start kept");
  property p_su_on; low_power_o |-> startup_supply_source_o; endproperty
  a_su_on: assert property (p_su_on) else $error("source off");
  property p_su_off;
    stop_o || switch_enable_o |-> !startup_supply_source_o;
  endproperty
  a_su_off: assert property (p_su_off) else $error("source on");
  property p_stop; stop_o |-> !switch_enable_o && !low_power_o; endproperty
  a_stop: assert property (p_stop) else $error("stop not exclusive");
endmodule // prs_sequencer_sva
bind prs_sequencer prs_sequencer_sva i_sva (
  .clk_i                       (clk_i),
  .rst_b_i                     (rst_b_i),
  .switch_overcurrent_trip_i   (switch_overcurrent_trip_i),
  .input_surge_trip_i          (input_surge_trip_i),
  .low_input_trip_i            (low_input_trip_i),
  .feedback_loss_trip_i        (feedback_loss_trip_i),
  .feedback_pull_low_disable_i (feedback_pull_low_disable_i),
  .control_pull_low_disable_i  (control_pull_low_disable_i),
  .supply_ready_i              (supply_ready_i),
  .control_pull_high_disable_i (control_pull_high_disable_i),
  .switch_enable_o             (switch_enable_o),
  .startup_supply_source_o     (startup_supply_source_o),
  .soft_start_reset_o          (soft_start_reset_o),
  .soft_start_active_o         (soft_start_active_o),
  .low_power_o                 (low_power_o),
  .stop_o                      (stop_o)
);
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the protection and restart sequencer
`include "prs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
  import prs_pkg::*;
;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic [7:0] req = 8'h00;
  logic [7:0] flag;
  logic [5:0] outs;
  integer     seed = 32'h94DCBAB1;
  integer     mismatches = 0;
  integer     compares = 0;
  integer     n;
  localparam int OCP_CYC   = `PRS_US2CYC(`PRS_OCP_HOLD_US);
  localparam int LOWIN_CYC = `PRS_US2CYC(`PRS_LOWIN_US);
  localparam int FBL_CYC   = `PRS_US2CYC(`PRS_FBLOSS_US);
  localparam int DIS_CYC   = `PRS_US2CYC(`PRS_DIS_US);
  localparam int REC_CYC   = `PRS_US2CYC(`PRS_REC_US);
  localparam int SOFT_CYC  = `PRS_US2CYC(`PRS_SOFT_US);
  always #50 clk_i = ~clk_i;
  prs_flag_model i_flags (.req_i(req), .clk_i(clk_i), .flag_o(flag));
  prs_sequencer i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .switch_overcurrent_trip_i(flag[0]), .input_surge_trip_i(flag[1]),
    .low_input_trip_i(flag[2]), .feedback_loss_trip_i(flag[3]),
    .feedback_pull_low_disable_i(flag[4]),
    .control_pull_low_disable_i(flag[5]),
    .control_pull_high_disable_i(flag[6]), .supply_ready_i(flag[7]),
    .switch_enable_o(outs[5]), .startup_supply_source_o(outs[4]),
    .soft_start_reset_o(outs[3]), .soft_start_active_o(outs[2]),
    .low_power_o(outs[1]), .stop_o(outs[0]));
  function automatic logic [5:0] exp_of(prs_state_t s);
    case (s)
      PRS_ST_SOFT:   return 6'h24;
      PRS_ST_ACTIVE: return 6'h20;
      PRS_ST_STOP:   return 6'h01;
      default:       return 6'h1A;
    endcase
  endfunction
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input integer k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic wait_st(input prs_state_t s, input integer lim);
    n = 0;
    @(negedge clk_i);
    while (outs !== exp_of(s) && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(outs, exp_of(s));
  endtask
  task automatic hold(input integer i, input integer len, input prs_state_t s);
    @(posedge clk_i);
    req[i] <= 1'b1;
    tick(len);
    @(negedge clk_i);
    chk(outs, exp_of(s));
    @(posedge clk_i);
    req[i] <= 1'b0;
  endtask
  // trip held past its interval, then recovery must last the full interval
  task automatic recover(input integer i, input integer len);
    hold(i, len + 10, PRS_ST_RECOVER);
    tick(REC_CYC - 30);
    wait_st(PRS_ST_RECOVER, 1);
    wait_st(PRS_ST_SOFT, 40);
  endtask
  task automatic pulse(input integer i, input integer len);
    @(posedge clk_i);
    req[i] <= 1'b1;
    tick(len);
    req[i] <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #9ms;
    mismatches++;
    print_verdict();
  end
  initial
  begin
    tick(8);
    rst_b_i <= 1'b1;
    wait_st(PRS_ST_LOWPWR, 1);
    @(posedge clk_i);
    req[7] <= 1'b1;
    wait_st(PRS_ST_SOFT, 5);
    // both trips outlast their intervals; only the soft-start mask saves us
    pulse(2, LOWIN_CYC + 5 + {$random(seed)} % 100);
    pulse(3, FBL_CYC + 5 + {$random(seed)} % 100);
    wait_st(PRS_ST_SOFT, 1);
    pulse(0, 3);
    wait_st(PRS_ST_STOP, 6);
    tick(900);
    wait_st(PRS_ST_STOP, 1);
    wait_st(PRS_ST_ACTIVE, 200);
    repeat (4)
    begin
      pulse(2, 10 + {$random(seed)} % 2000);
      pulse(3, 10 + {$random(seed)} % 2000);
      pulse(6, 10 + {$random(seed)} % 2000);
      wait_st(PRS_ST_ACTIVE, 1);
      pulse(4, 3 + {$random(seed)} % 50);
      @(negedge clk_i);
      chk({5'h00, outs[5]}, 6'h00);
      wait_st(PRS_ST_ACTIVE, 5);
    end
    hold(1, 50, PRS_ST_STOP);
    wait_st(PRS_ST_ACTIVE, 4);
    hold(1, 10100, PRS_ST_RECOVER);
    wait_st(PRS_ST_SOFT, 5);
    hold(5, 4, PRS_ST_LOWPWR);
    wait_st(PRS_ST_SOFT, 5);
    // soft-start timing restarted from zero on the last low power entry
    tick(SOFT_CYC - 20);
    wait_st(PRS_ST_SOFT, 1);
    wait_st(PRS_ST_ACTIVE, 40);
    recover(2, LOWIN_CYC);
    recover(6, DIS_CYC);
    pulse(0, 3);
    wait_st(PRS_ST_STOP, 6);
    wait_st(PRS_ST_ACTIVE, OCP_CYC + 20);
    recover(3, FBL_CYC);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    wait_st(PRS_ST_LOWPWR, 3);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    wait_st(PRS_ST_SOFT, 5);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
